// ### cfg_status_pkg.sv
// constants, bit positions and types for the status and error register pair
package cfg_status_pkg;

   // ==========================================================
   // timing
   localparam int unsigned CLK_FREQ_KHZ = 250000;
   localparam int unsigned INIT_TIMEOUT_MS = 500;
   localparam int unsigned INIT_TIMEOUT_CYCLES = INIT_TIMEOUT_MS * CLK_FREQ_KHZ;
   localparam int unsigned INIT_CNT_W = 27;

   // ==========================================================
   // register offsets and reset values
   localparam logic [6:0] STATUS_BYTE_OFS = 7'h04;
   localparam logic [6:0] ERROR_BYTE_OFS = 7'h08;
   localparam logic [5:0] STATUS_WORD_OFS = 6'h02;
   localparam logic [5:0] ERROR_WORD_OFS = 6'h04;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [31:0] ERROR_RESET = 32'h0000_0000;
   localparam logic [15:0] READ_DATA_RESET = 16'h0000;

   // ==========================================================
   // status word fields
   localparam int ST_ENGINE_LOCK = 0;
   localparam int ST_HOST_LOCK = 1;
   localparam int ST_ENGINE_ERR = 2;
   localparam int ST_CARD_CTRL_ERR = 3;
   localparam int ST_CARD_PRESENT = 4;
   localparam int ST_BUF_READY = 5;
   localparam int ST_BUF_DIR = 6;
   localparam int ST_CFG_DONE = 7;
   localparam int ST_CMD_ACCEPT = 8;
   localparam int ST_AUTO_START = 9;
   localparam int ST_FSEL_LSB = 13;
   localparam int ST_CARD_MIRROR_LSB = 17;

   // ==========================================================
   // error word fields
   localparam int ER_CARD_EVT_LSB = 0;
   localparam int ER_FILE_LOC = 5;
   localparam int ER_ENGINE_EVT_LSB = 6;
   localparam int ER_INIT_TIMEOUT = 9;
   localparam int ER_CARD_MIRROR_LSB = 11;
   localparam logic [31:0] ER_STICKY_MASK = 32'h0000_03DF;

   // ==========================================================
   // pin synchroniser lanes
   localparam int SYNC_W = 16;
   localparam int SY_ADDR_LSB = 0;
   localparam int SY_CE_N = 7;
   localparam int SY_OE_N = 8;
   localparam int SY_WE_N = 9;
   localparam int SY_AUTO_START = 10;
   localparam int SY_FSEL_LSB = 11;
   localparam int SY_PRESENT = 14;
   localparam int SY_INIT = 15;
   localparam logic [SYNC_W-1:0] SYNC_RESET = 16'h0380;

   // ==========================================================
   // init monitor timer states
   typedef enum logic [2:0] {
      TMR_IDLE = 3'b001,
      TMR_WAIT = 3'b010,
      TMR_DONE = 3'b100
   } init_timer_state_type;

endpackage

// ### pin_sync_if.sv
// carrier between the register bank and its pin synchroniser
`timescale 1ns/1ps
interface pin_sync_if;
   import cfg_status_pkg::*;
   logic [SYNC_W-1:0] raw;
   logic [SYNC_W-1:0] synced;
   modport sync_side (input raw, output synced);
   modport user_side (output raw, input synced);
endinterface

// ### pin_synchronizer.sv
// two-flop synchronisers for every pin input
`timescale 1ns/1ps
module pin_synchronizer (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // pins in, synchronised levels out
   pin_sync_if.sync_side sync_port
);
   import cfg_status_pkg::*;

   // ==========================================================
   // one synchroniser per lane
   genvar g;
   generate
      for (g = 0; g < SYNC_W; g++) begin : g_lane
         logic meta_q;
         logic stable_q;
         always_ff @(posedge clk_sys_i or negedge rstn_i) begin
            if (!rstn_i) begin
               meta_q <= SYNC_RESET[g];
               stable_q <= SYNC_RESET[g];
            end else begin
               meta_q <= sync_port.raw[g];
               stable_q <= meta_q;
            end
         end
         assign sync_port.synced[g] = stable_q;
      end
   endgenerate

endmodule

// ### config_manager_status_error_regs.sv
// read-only controller status and error registers on the parallel host bus
//
// Overview of operation
// - status word sits at byte 04h-07h or word 02h-03h.
// - bit 0 shows engine holds card lock, bit 1 host holds it.
// - bit 2 summarises engine errors, bit 3 card controller errors.
// - bit 4 is one while a card is present.
// - bit 5 is one while the data buffer can be transferred.
// - bit 6 gives buffer direction, zero read, one write.
// - bit 7 is one only after the whole configuration completed.
// - bit 8 is one while the card controller accepts a command.
// - bit 9 reflects the auto start pin.
// - bits 13-15 reflect the file select pins.
// - bit 17 mirrors card busy; host ignores bits 1-6 then.
// - bits 18-23 mirror card ready, fault, seek, request, corrected, error.
// - error word sits at byte 08h-0Bh or word 04h-05h.
// - error bits 0 and 1 flag card reset and ready timeouts.
// - error bits 2 and 3 flag failed read/identify and write commands.
// - error bit 4 flags a sector valid timeout.
// - error bit 5 flags an invalid selected file location.
// - error bits 6-8 flag chain, fetch and instruction failures.
// - error bit 9 flags init monitor not high within 500 ms.
// - error bits 11-15 mirror card bad block to general error flags.
// - byte mode reads four lanes, word mode two halves low first.
`timescale 1ns/1ps
module config_manager_status_error_regs #(
   parameter int unsigned INIT_TIMEOUT_CYCLES_P = cfg_status_pkg::INIT_TIMEOUT_CYCLES
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rstn_i,
   // host bus pins
   input wire logic [6:0] mpu_addr_i,
   input wire logic mpu_ce_n_i,
   input wire logic mpu_oe_n_i,
   input wire logic mpu_we_n_i,
   output logic [15:0] mpu_data_o,
   output logic mpu_data_oe_o,
   // bus mode from the bus mode register
   input wire logic word_mode_i,
   // configuration pins
   input wire logic auto_start_pin_i,
   input wire logic [2:0] file_select_pins_i,
   input wire logic card_present_pin_i,
   input wire logic init_monitor_input_i,
   // controller state
   input wire logic engine_holds_card_lock_i,
   input wire logic host_holds_card_lock_i,
   input wire logic buffer_ready_flag_i,
   input wire logic buffer_direction_flag_i,
   input wire logic configuration_complete_flag_i,
   input wire logic command_accept_flag_i,
   // card status mirrors: busy, ready, fault, seek, request, corrected, error
   input wire logic [6:0] card_status_mirror_i,
   // card error mirrors: bad block, uncorrectable, id missing, aborted, general
   input wire logic [4:0] card_error_mirror_i,
   // error events, file location selection, init timer start and error clear
   input wire logic [4:0] card_err_event_i,
   input wire logic [2:0] engine_err_event_i,
   input wire logic file_select_override_enable_i,
   input wire logic [2:0] file_select_override_field_i,
   input wire logic [7:0] file_valid_mask_i,
   input wire logic config_start_i,
   input wire logic error_clear_i
);
   import cfg_status_pkg::*;

   // ==========================================================
   // pin synchronisation
   pin_sync_if sync_bus ();

   assign sync_bus.raw = {init_monitor_input_i, card_present_pin_i, file_select_pins_i, auto_start_pin_i,
                          mpu_we_n_i, mpu_oe_n_i, mpu_ce_n_i, mpu_addr_i};

   pin_synchronizer u_pin_sync (
      .clk_sys_i (clk_sys_i),
      .rstn_i (rstn_i),
      .sync_port (sync_bus.sync_side)
   );

   logic [6:0] bus_addr;
   logic bus_ce_n;
   logic bus_oe_n;
   logic bus_we_n;
   logic pin_auto_start;
   logic [2:0] pin_fsel;
   logic pin_present;
   logic pin_init;

   assign bus_addr = sync_bus.synced[SY_ADDR_LSB +: 7];
   assign bus_ce_n = sync_bus.synced[SY_CE_N];
   assign bus_oe_n = sync_bus.synced[SY_OE_N];
   assign bus_we_n = sync_bus.synced[SY_WE_N];
   assign pin_auto_start = sync_bus.synced[SY_AUTO_START];
   assign pin_fsel = sync_bus.synced[SY_FSEL_LSB +: 3];
   assign pin_present = sync_bus.synced[SY_PRESENT];
   assign pin_init = sync_bus.synced[SY_INIT];

   // ==========================================================
   // init monitor timer
   init_timer_state_type tmr_state_q;
   init_timer_state_type tmr_state_d;
   logic [INIT_CNT_W-1:0] tmr_cnt_q;
   logic [INIT_CNT_W-1:0] tmr_cnt_d;
   logic tmr_expired;
   logic [INIT_CNT_W-1:0] tmr_limit;

   assign tmr_limit = INIT_CNT_W'(INIT_TIMEOUT_CYCLES_P - 1);

   always_comb begin
      tmr_state_d = tmr_state_q;
      tmr_cnt_d = tmr_cnt_q;
      tmr_expired = 1'b0;
      case (tmr_state_q)
         TMR_IDLE, TMR_DONE: begin
            if (config_start_i) begin
               tmr_state_d = TMR_WAIT;
               tmr_cnt_d = '0;
            end
         end
         TMR_WAIT: begin
            if (pin_init) begin
               tmr_state_d = TMR_DONE;
            end else if (tmr_cnt_q == tmr_limit) begin
               tmr_expired = 1'b1;
               tmr_state_d = TMR_DONE;
            end else begin
               tmr_cnt_d = tmr_cnt_q + 1'b1;
            end
         end
         default: begin
            tmr_state_d = TMR_IDLE;
            tmr_cnt_d = '0;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tmr_state_q <= TMR_IDLE;
         tmr_cnt_q <= '0;
      end else begin
         tmr_state_q <= tmr_state_d;
         tmr_cnt_q <= tmr_cnt_d;
      end
   end

   // ==========================================================
   // sticky error bits
   logic [31:0] error_q;
   logic [31:0] error_d;
   logic [31:0] error_events;

   always_comb begin
      error_events = '0;
      error_events[ER_CARD_EVT_LSB +: 5] = card_err_event_i;
      error_events[ER_ENGINE_EVT_LSB +: 3] = engine_err_event_i;
      error_events[ER_INIT_TIMEOUT] = tmr_expired;
      // a new event wins over a clear in the same cycle
      error_d = ((error_clear_i ? '0 : error_q) | error_events) & ER_STICKY_MASK;
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         error_q <= ERROR_RESET;
      end else begin
         error_q <= error_d;
      end
   end

   // ==========================================================
   // register word assembly
   logic [31:0] status_word;
   logic [31:0] error_word;
   logic [2:0] file_sel;

   always_comb begin
      file_sel = file_select_override_enable_i ? file_select_override_field_i : pin_fsel;
      error_word = error_q;
      error_word[ER_FILE_LOC] = ~file_valid_mask_i[file_sel];
      error_word[ER_CARD_MIRROR_LSB +: 5] = card_error_mirror_i;
      status_word = STATUS_RESET;
      status_word[ST_ENGINE_LOCK] = engine_holds_card_lock_i;
      status_word[ST_HOST_LOCK] = host_holds_card_lock_i;
      status_word[ST_ENGINE_ERR] = |error_word[ER_INIT_TIMEOUT:ER_FILE_LOC];
      status_word[ST_CARD_CTRL_ERR] = |error_word[ER_CARD_EVT_LSB +: 5];
      status_word[ST_CARD_PRESENT] = pin_present;
      status_word[ST_BUF_READY] = buffer_ready_flag_i;
      status_word[ST_BUF_DIR] = buffer_direction_flag_i;
      status_word[ST_CFG_DONE] = configuration_complete_flag_i;
      status_word[ST_CMD_ACCEPT] = command_accept_flag_i;
      status_word[ST_AUTO_START] = pin_auto_start;
      status_word[ST_FSEL_LSB +: 3] = pin_fsel;
      status_word[ST_CARD_MIRROR_LSB +: 7] = card_status_mirror_i;
   end

   // ==========================================================
   // host read port
   logic [15:0] rd_data_q;
   logic [15:0] rd_data_d;
   logic rd_oe_q;
   logic rd_oe_d;
   logic read_active;
   logic [31:0] sel_word;
   logic hit;

   assign read_active = !bus_ce_n && !bus_oe_n && bus_we_n;

   always_comb begin
      sel_word = '0;
      hit = 1'b0;
      rd_data_d = READ_DATA_RESET;
      if (word_mode_i) begin
         if (bus_addr[6:2] == STATUS_WORD_OFS[5:1]) begin
            sel_word = status_word;
            hit = 1'b1;
         end else if (bus_addr[6:2] == ERROR_WORD_OFS[5:1]) begin
            sel_word = error_word;
            hit = 1'b1;
         end
         rd_data_d = bus_addr[1] ? sel_word[31:16] : sel_word[15:0];
      end else begin
         if (bus_addr[6:2] == STATUS_BYTE_OFS[6:2]) begin
            sel_word = status_word;
            hit = 1'b1;
         end else if (bus_addr[6:2] == ERROR_BYTE_OFS[6:2]) begin
            sel_word = error_word;
            hit = 1'b1;
         end
         rd_data_d = {8'h00, sel_word[8*bus_addr[1:0] +: 8]};
      end
      rd_oe_d = read_active && hit;
      if (!rd_oe_d) begin
         rd_data_d = READ_DATA_RESET;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rd_data_q <= READ_DATA_RESET;
         rd_oe_q <= 1'b0;
      end else begin
         rd_data_q <= rd_data_d;
         rd_oe_q <= rd_oe_d;
      end
   end

   assign mpu_data_o = rd_data_q;
   assign mpu_data_oe_o = rd_oe_q;

   // ==========================================================
   // checks
   property p_status_byte0_read;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (read_active && !word_mode_i && bus_addr == 7'h04) |=>
      (rd_oe_q && rd_data_q == {8'h00, $past(status_word[7:0])});
   endproperty
   a_status_byte0_read: assert property (p_status_byte0_read) else $error("status byte 0 read wrong");

   property p_error_high_half_read;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (read_active && word_mode_i && bus_addr[6:1] == 6'h05) |=> (rd_oe_q && rd_data_q == $past(error_word[31:16]));
   endproperty
   a_error_high_half_read: assert property (p_error_high_half_read) else $error("error high half read wrong");

   property p_no_drive_on_write;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (!bus_we_n || bus_ce_n) |=> (!rd_oe_q && rd_data_q == 16'h0000);
   endproperty
   a_no_drive_on_write: assert property (p_no_drive_on_write) else $error("bus driven outside a read");

   property p_reserved_zero;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (status_word[12:10] == 3'h0) && !status_word[16] && (status_word[31:24] == 8'h00) &&
      !error_word[10] && (error_word[31:16] == 16'h0000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_reset_timeout_sticky;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      card_err_event_i[0] |=> error_word[0] ##1 (error_word[0] || $past(error_clear_i));
   endproperty
   a_reset_timeout_sticky: assert property (p_reset_timeout_sticky) else $error("card reset timeout lost");

   property p_event_beats_clear;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (engine_err_event_i[0] && error_clear_i) |=> error_word[6];
   endproperty
   a_event_beats_clear: assert property (p_event_beats_clear) else $error("clear beat a new event");

   property p_init_timeout;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (tmr_state_q == TMR_WAIT && tmr_cnt_q == tmr_limit && !pin_init) |=> (error_word[9] && tmr_state_q == TMR_DONE);
   endproperty
   a_init_timeout: assert property (p_init_timeout) else $error("init timeout not flagged");

   property p_init_in_time;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      (tmr_state_q == TMR_WAIT && pin_init && !error_word[9] && !engine_err_event_i[0]) |=> !error_word[9];
   endproperty
   a_init_in_time: assert property (p_init_in_time) else $error("init timeout flagged after init rose");

   property p_engine_summary;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      status_word[2] == (|error_word[9:5]) && status_word[3] == (|error_word[4:0]);
   endproperty
   a_engine_summary: assert property (p_engine_summary) else $error("error summary bits wrong");

   property p_auto_start_pin;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      $past(rstn_i, 3) |-> status_word[9] == $past(auto_start_pin_i, 2);
   endproperty
   a_auto_start_pin: assert property (p_auto_start_pin) else $error("auto start pin not reflected");

   property p_busy_mirror;
      @(posedge clk_sys_i) disable iff (!rstn_i)
      status_word[23:17] == card_status_mirror_i && error_word[15:11] == card_error_mirror_i;
   endproperty
   a_busy_mirror: assert property (p_busy_mirror) else $error("card mirror bits wrong");

endmodule

// ### host_bus_model.sv
// host processor model on the parallel register bus
`timescale 1ns/1ps
module host_bus_model (
   // clock
   input wire logic clk_sys_i,
   // bus pins
   output logic [6:0] mpu_addr_o,
   output logic mpu_ce_n_o,
   output logic mpu_oe_n_o,
   output logic mpu_we_n_o,
   input wire logic [15:0] mpu_data_i,
   input wire logic mpu_data_oe_i
);
   initial begin
      mpu_addr_o = 7'h7F;
      mpu_ce_n_o = 1'b1;
      mpu_oe_n_o = 1'b1;
      mpu_we_n_o = 1'b1;
   end
   // ==========================================================
   // one access, pins held until the answer is sampled
   task automatic access(input logic [6:0] a, input logic wr, output logic [15:0] d, output logic oe);
      @(posedge clk_sys_i);
      mpu_addr_o <= a;
      mpu_ce_n_o <= 1'b0;
      mpu_oe_n_o <= wr;
      mpu_we_n_o <= ~wr;
      repeat (3) @(posedge clk_sys_i);
      #1;
      d = mpu_data_i;
      oe = mpu_data_oe_i;
      @(posedge clk_sys_i);
      mpu_ce_n_o <= 1'b1;
      mpu_oe_n_o <= 1'b1;
      mpu_we_n_o <= 1'b1;
      mpu_addr_o <= ~a;
   endtask
endmodule

// ### config_manager_status_error_regs_test.sv
// self-checking bench for the status and error register pair
`timescale 1ns/1ps
module config_manager_status_error_regs_test;
   import cfg_status_pkg::*;
   localparam int unsigned TMO = 50;
   logic clk_sys_i, rstn_i, word_mode, ovr_en, cfg_start, init_in, err_clr, ce_n, oe_n, we_n, data_oe;
   logic [22:0] src;
   logic [4:0] card_evt;
   logic [2:0] eng_evt, ovr_field;
   logic [7:0] valid_mask;
   logic [9:0] sticky;
   logic [6:0] addr;
   logic [15:0] data;
   int errors, n_tests;
   config_manager_status_error_regs #(.INIT_TIMEOUT_CYCLES_P(TMO)) dut (
      .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .mpu_addr_i(addr), .mpu_ce_n_i(ce_n), .mpu_oe_n_i(oe_n),
      .mpu_we_n_i(we_n), .mpu_data_o(data), .mpu_data_oe_o(data_oe), .word_mode_i(word_mode),
      .auto_start_pin_i(src[7]), .file_select_pins_i(src[10:8]), .card_present_pin_i(src[2]),
      .init_monitor_input_i(init_in), .engine_holds_card_lock_i(src[0]), .host_holds_card_lock_i(src[1]),
      .buffer_ready_flag_i(src[3]), .buffer_direction_flag_i(src[4]), .configuration_complete_flag_i(src[5]),
      .command_accept_flag_i(src[6]), .card_status_mirror_i(src[17:11]), .card_error_mirror_i(src[22:18]),
      .card_err_event_i(card_evt), .engine_err_event_i(eng_evt), .file_select_override_enable_i(ovr_en),
      .file_select_override_field_i(ovr_field), .file_valid_mask_i(valid_mask), .config_start_i(cfg_start),
      .error_clear_i(err_clr));
   host_bus_model host (.clk_sys_i(clk_sys_i), .mpu_addr_o(addr), .mpu_ce_n_o(ce_n), .mpu_oe_n_o(oe_n),
      .mpu_we_n_o(we_n), .mpu_data_i(data), .mpu_data_oe_i(data_oe));
   // ==========================================================
   // expected words
   function automatic logic [9:0] err_lo();
      logic [2:0] s;
      s = ovr_en ? ovr_field : src[10:8];
      return {sticky[9:6], ~valid_mask[s], sticky[4:0]};
   endfunction
   function automatic logic [31:0] exp_status();
      logic [9:0] e;
      e = err_lo();
      return {8'h00, src[17:11], 1'b0, src[10:8], 3'h0, src[7:2], |e[4:0], |e[9:5], src[1:0]};
   endfunction
   task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", name, e, g);
         errors++;
      end
   endtask
   // ==========================================================
   // whole register read in the current bus mode
   task automatic read_reg(input logic [6:0] base, output logic [31:0] v);
      logic [15:0] d;
      logic oe;
      logic wm;
      // let a mode change made at the last edge settle before it is read
      @(posedge clk_sys_i);
      wm = word_mode;
      for (int i = 0; i < (wm ? 2 : 4); i++) begin
         if (wm) begin
            host.access({base[6:1] + 6'(i), 1'b1}, 1'b0, d, oe);
            v[16*i +: 16] = d;
         end else begin
            host.access(base + 7'(i), 1'b0, d, oe);
            chk("byte_high", 32'h0, {24'h0, d[15:8]});
            v[8*i +: 8] = d[7:0];
         end
         chk("drive", 32'h1, {31'h0, oe});
      end
   endtask
   task automatic check_regs();
      logic [31:0] v, m;
      m = src[11] ? 32'hFFFF_FF81 : 32'hFFFF_FFFF;
      read_reg(STATUS_BYTE_OFS, v);
      chk("status", exp_status() & m, v & m);
      read_reg(ERROR_BYTE_OFS, v);
      chk("error", {16'h0, src[22:18], 1'b0, err_lo()}, v);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_walk();
      for (int m = 0; m < 2; m++) begin
         for (int b = 0; b < 24; b++) begin
            @(posedge clk_sys_i);
            word_mode <= m[0];
            src <= (b == 23) ? 23'h7F_FFFF : 23'h1 << b;
            check_regs();
         end
      end
      @(posedge clk_sys_i);
      src <= 23'h0;
      word_mode <= 1'b0;
   endtask
   task automatic t_events();
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys_i);
         {eng_evt, card_evt} <= 8'h01 << i;
         err_clr <= (i == 0) || (i == 5);
         @(posedge clk_sys_i);
         {eng_evt, card_evt} <= 8'h00;
         err_clr <= 1'b0;
         sticky = (i == 5) ? 10'h000 : sticky;
         sticky[i < 5 ? i : i + 1] = 1'b1;
         check_regs();
      end
      @(posedge clk_sys_i);
      err_clr <= 1'b1;
      @(posedge clk_sys_i);
      err_clr <= 1'b0;
      sticky = 10'h000;
      check_regs();
   endtask
   task automatic t_file_loc();
      for (int i = 0; i < 16; i++) begin
         @(posedge clk_sys_i);
         ovr_en <= i[3];
         ovr_field <= i[3] ? i[2:0] : ~i[2:0];
         src[10:8] <= i[3] ? ~i[2:0] : i[2:0];
         valid_mask <= ~(8'h01 << i[2:0]);
         check_regs();
      end
      @(posedge clk_sys_i);
      valid_mask <= 8'hFF;
      ovr_en <= 1'b0;
      src <= 23'h0;
   endtask
   task automatic t_init(input logic rise);
      @(posedge clk_sys_i);
      cfg_start <= 1'b1;
      @(posedge clk_sys_i);
      cfg_start <= 1'b0;
      repeat (5) @(posedge clk_sys_i);
      init_in <= rise;
      repeat (TMO + 10) @(posedge clk_sys_i);
      sticky[9] = ~rise;
      check_regs();
      @(posedge clk_sys_i);
      err_clr <= 1'b1;
      init_in <= 1'b0;
      @(posedge clk_sys_i);
      err_clr <= 1'b0;
      sticky = 10'h000;
   endtask
   task automatic t_refused();
      logic [15:0] d;
      logic oe;
      logic [6:0] a[4] = '{7'h04, 7'h00, 7'h0C, 7'h40};
      for (int i = 0; i < 4; i++) begin
         host.access(a[i], i == 0, d, oe);
         chk("refused", 32'h0, {15'h0, oe, d});
      end
      check_regs();
   endtask
   // ==========================================================
   // run control
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   initial begin
      repeat (100000) @(posedge clk_sys_i);
      errors++;
      end_sim();
   end
   initial begin
      errors = 0;
      n_tests = 0;
      rstn_i = 1'b0;
      word_mode = 1'b0;
      ovr_en = 1'b0;
      ovr_field = 3'h0;
      cfg_start = 1'b0;
      init_in = 1'b0;
      err_clr = 1'b0;
      src = 23'h0;
      card_evt = 5'h00;
      eng_evt = 3'h0;
      valid_mask = 8'hFF;
      sticky = 10'h000;
      repeat (16) @(posedge clk_sys_i);
      rstn_i <= 1'b1;
      #1;
      chk("reset_bus", 32'h0, {15'h0, data_oe, data});
      check_regs();
      t_walk();
      t_events();
      t_file_loc();
      t_init(1'b0);
      t_init(1'b1);
      t_refused();
      end_sim();
   end
endmodule
